// >>> common/ipc_pkg.sv
package ipc_pkg;

  // Clock and oscillator timing; the core clock is the oscillator itself.
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 4;
  localparam int OSC_PER_STATE = 2;
  localparam int STATES_PER_MC = 6;
  localparam int MC_PERIODS = OSC_PER_STATE * STATES_PER_MC;
  localparam int MC_CYCLES = (MC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Settling delay after a port-1 wake-up, as a least time in oscillator periods.
  localparam int WAKE_DELAY_PERIODS = 1536;
  localparam int WAKE_DELAY_CYCLES =
    (WAKE_DELAY_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least reset hold times expected from the outside party.
  localparam int RESET_HOLD_IDLE_MC = 2;
  localparam int RESET_HOLD_POWERDOWN_PERIODS = 24;

  // Power control register.
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RW_MASK = 8'h8f;
  localparam int BIT_IDLE_REQ = 0;
  localparam int BIT_POWERDOWN_REQ = 1;
  localparam int BIT_GENERAL_FLAG_LOW = 2;
  localparam int BIT_GENERAL_FLAG_HIGH = 3;
  localparam int BIT_BAUD_DOUBLE = 7;

  // Operating modes of the controller.
  typedef enum logic [1:0] {
    IPC_RUN,
    IPC_IDLE,
    IPC_POWERDOWN,
    IPC_WAKE
  } ipc_mode_t;

endpackage

// >>> common/ipc_delay_if.sv
`timescale 1ns/10ps
// Start and finish of the oscillator settling delay.
interface ipc_delay_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport cnt (input start, output done);
endinterface

// >>> hdl/ipc_wake_delay.sv
`timescale 1ns/10ps
module ipc_wake_delay #(
  parameter int DELAY_CYCLES = ipc_pkg::WAKE_DELAY_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the mode machine.
  ipc_delay_if.cnt dly
);

  localparam int CW = $clog2(DELAY_CYCLES + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
  } ipc_dly_state_t;

  ipc_dly_state_t s_q;
  ipc_dly_state_t s_d;

  // A start while busy is ignored so a bouncing wake pin cannot stretch the delay.
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (dly.start && !s_q.busy)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = CW'(DELAY_CYCLES - 1);
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dly.done = s_q.done;

  a_dly_load: assert property (@(posedge clk_i) disable iff (rst_i)
    dly.start && !s_q.busy |=> s_q.busy && s_q.cnt == CW'(DELAY_CYCLES - 1))
    else $error("Settling delay did not load its full count.");

endmodule // ipc_wake_delay

// >>> hdl/ipc_power_ctrl.sv
`timescale 1ns/10ps
// Function
// - Idle begins right after the instruction writing the idle request completes.
// - In Idle only the CPU clock stops; interrupt, timers and serial keep running.
// - Idle preserves all CPU state, registers and internal RAM.
// - In Idle ports hold their levels; both bus strobes are held high.
// - An enabled interrupt in Idle clears the mode bits, ending Idle.
// - After the handler returns, execution continues after the Idle instruction.
// - Reset also ends Idle; two machine cycles of reset suffice.
// - Power-down starts after the instruction setting its request; oscillator stops.
// - Power-down keeps RAM and registers; ports show latches; strobes driven low.
// - Power-down during external access: port 2 shows latch, port 0 floats.
// - Port-1 interrupt wake holds the internal clock off for 1536 periods.
// - Reset wake skips the settling delay; outside party waits for oscillator.
// - Reset restores every register value but leaves on-chip RAM unchanged.
// - Power control sits at direct address 87h, byte access only.
// - Bit 7 doubles the baud rate; bits 4 to 6 are reserved.
// - Bits 3 and 2 are software flags, writable with the idle request.
// - One machine cycle is six states of two oscillator periods.
module ipc_power_ctrl #(
  parameter int WAKE_DELAY_CYCLES = ipc_pkg::WAKE_DELAY_CYCLES,
  parameter int MC_CYCLES = ipc_pkg::MC_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Special function register port.
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_bit_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // CPU and interrupt status.
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic ext_access_i,
  // Port-1 wake pins and their enables.
  input wire logic [7:0] port1_wake_irq_i,
  input wire logic [7:0] port1_wake_en_i,
  // Clock gating.
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic mc_strobe_o,
  // Pin control.
  output logic strobe_force_o,
  output logic strobe_level_o,
  output logic port_freeze_o,
  output logic port2_latch_sel_o,
  output logic port0_float_o,
  // Status.
  output logic baud_double_o,
  output logic idle_o,
  output logic powerdown_o
);

  localparam int MCW = $clog2(MC_CYCLES);
  // The wake tally has a little headroom past the delay so it cannot wrap.
  localparam int WCW = $clog2(WAKE_DELAY_CYCLES + 4);

  typedef struct packed {
    ipc_pkg::ipc_mode_t mode;
    logic [7:0] power_control;
    logic [7:0] rdata;
    logic [7:0] wake_meta;
    logic [7:0] wake_sync;
    logic [MCW-1:0] mc_cnt;
    logic mc_strobe;
    logic ext_at_entry;
    logic dly_start;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic strobe_force;
    logic strobe_level;
    logic port_freeze;
    logic port2_latch_sel;
    logic port0_float;
    logic idle;
    logic powerdown;
    logic [WCW-1:0] wake_cnt;
  } ipc_state_t;

  // Clock enables start on so the core runs through reset into normal operation.
  localparam ipc_state_t ST_RESET = '{
    mode: ipc_pkg::IPC_RUN,
    power_control: ipc_pkg::POWER_CONTROL_RESET,
    cpu_clk_en: 1'b1,
    periph_clk_en: 1'b1,
    osc_en: 1'b1,
    default: '0
  };

  ipc_state_t s_q;
  ipc_state_t s_d;
  logic [7:0] pc_wr;
  logic enter_any;
  logic wake_hit;

  ipc_delay_if dly ();

  // Settling delay counter used only for port-1 wake-up.
  ipc_wake_delay #(
    .DELAY_CYCLES(WAKE_DELAY_CYCLES)
  ) u_wake_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dly(dly.cnt)
  );

  // Decodes a direct address onto the power control register.
  function automatic logic hits_power_control(input logic [7:0] addr);
    return addr == ipc_pkg::POWER_CONTROL_ADDR;
  endfunction

  // Bit-wise writes are dropped here because the register has no bit address.
  always_comb
  begin
    pc_wr = s_q.power_control;
    if (sfr_wr_i && !sfr_bit_wr_i && hits_power_control(sfr_addr_i))
    begin
      pc_wr = sfr_wdata_i & ipc_pkg::POWER_CONTROL_RW_MASK;
    end
  end

  // Entry is judged on the value after this cycle's write, so a write in the
  // completing instruction takes effect at that instruction's end.
  assign enter_any = instr_done_i &&
    (pc_wr[ipc_pkg::BIT_IDLE_REQ] || pc_wr[ipc_pkg::BIT_POWERDOWN_REQ]);

  // Only the synchronised copy of the wake pins is looked at.
  assign wake_hit = |(s_q.wake_sync & port1_wake_en_i);

  assign dly.start = s_q.dly_start;

  // Next-state logic for the whole controller.
  always_comb
  begin
    s_d = s_q;
    s_d.wake_meta = port1_wake_irq_i;
    s_d.wake_sync = s_q.wake_meta;
    s_d.dly_start = 1'b0;
    s_d.rdata = 8'h00;
    s_d.power_control = pc_wr;
    if (sfr_rd_i && hits_power_control(sfr_addr_i))
    begin
      s_d.rdata = s_q.power_control & ipc_pkg::POWER_CONTROL_RW_MASK;
    end
    case (s_q.mode)
      ipc_pkg::IPC_RUN:
      begin
        if (enter_any)
        begin
          if (pc_wr[ipc_pkg::BIT_POWERDOWN_REQ])
          begin
            s_d.mode = ipc_pkg::IPC_POWERDOWN;
            s_d.ext_at_entry = ext_access_i;
          end
          else
          begin
            s_d.mode = ipc_pkg::IPC_IDLE;
          end
        end
      end
      ipc_pkg::IPC_IDLE:
      begin
        // Flags stay so the handler can tell an idle wake from a normal one.
        if (irq_pending_i)
        begin
          s_d.mode = ipc_pkg::IPC_RUN;
          s_d.power_control[ipc_pkg::BIT_IDLE_REQ] = 1'b0;
          s_d.power_control[ipc_pkg::BIT_POWERDOWN_REQ] = 1'b0;
        end
      end
      ipc_pkg::IPC_POWERDOWN:
      begin
        if (wake_hit)
        begin
          s_d.mode = ipc_pkg::IPC_WAKE;
          s_d.dly_start = 1'b1;
        end
      end
      ipc_pkg::IPC_WAKE:
      begin
        if (dly.done)
        begin
          s_d.mode = ipc_pkg::IPC_RUN;
          s_d.power_control[ipc_pkg::BIT_IDLE_REQ] = 1'b0;
          s_d.power_control[ipc_pkg::BIT_POWERDOWN_REQ] = 1'b0;
          s_d.ext_at_entry = 1'b0;
        end
      end
      default:
      begin
        s_d.mode = ipc_pkg::IPC_RUN;
      end
    endcase

    // Machine-cycle timebase; it runs only in Run and Idle, so it stops in Power-down and while the oscillator settles.
    s_d.mc_strobe = 1'b0;
    if (s_q.mode == ipc_pkg::IPC_RUN || s_q.mode == ipc_pkg::IPC_IDLE)
    begin
      if (s_q.mc_cnt == MCW'(MC_CYCLES - 1))
      begin
        s_d.mc_cnt = '0;
        s_d.mc_strobe = 1'b1;
      end
      else
      begin
        s_d.mc_cnt = s_q.mc_cnt + 1'b1;
      end
    end

    // Pin and clock controls follow the next mode so they change with it.
    s_d.cpu_clk_en = s_d.mode == ipc_pkg::IPC_RUN;
    s_d.periph_clk_en = s_d.mode == ipc_pkg::IPC_RUN ||
      s_d.mode == ipc_pkg::IPC_IDLE;
    s_d.osc_en = s_d.mode != ipc_pkg::IPC_POWERDOWN;
    s_d.strobe_force = s_d.mode != ipc_pkg::IPC_RUN;
    s_d.strobe_level = s_d.mode == ipc_pkg::IPC_IDLE;
    s_d.port_freeze = s_d.mode == ipc_pkg::IPC_IDLE;
    s_d.port2_latch_sel = s_d.mode == ipc_pkg::IPC_POWERDOWN ||
      s_d.mode == ipc_pkg::IPC_WAKE;
    s_d.port0_float = s_d.port2_latch_sel && s_d.ext_at_entry;

    // Mode flags are registered so the status outputs leave a flip-flop directly.
    s_d.idle = s_d.mode == ipc_pkg::IPC_IDLE;
    s_d.powerdown = s_d.mode == ipc_pkg::IPC_POWERDOWN;

    // Cycles spent settling after a port-1 wake; the wake checks measure it.
    if (s_q.mode == ipc_pkg::IPC_WAKE)
    begin
      s_d.wake_cnt = s_q.wake_cnt + 1'b1;
    end
    else
    begin
      s_d.wake_cnt = '0;
    end
  end

  // Reset lands every field on its defined value and never starts the settling
  // delay; the outside party holds reset until the oscillator is stable.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= ST_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign sfr_rdata_o = s_q.rdata;
  assign cpu_clk_en_o = s_q.cpu_clk_en;
  assign periph_clk_en_o = s_q.periph_clk_en;
  assign osc_en_o = s_q.osc_en;
  assign mc_strobe_o = s_q.mc_strobe;
  assign strobe_force_o = s_q.strobe_force;
  assign strobe_level_o = s_q.strobe_level;
  assign port_freeze_o = s_q.port_freeze;
  assign port2_latch_sel_o = s_q.port2_latch_sel;
  assign port0_float_o = s_q.port0_float;
  assign baud_double_o = s_q.power_control[ipc_pkg::BIT_BAUD_DOUBLE];
  assign idle_o = s_q.idle;
  assign powerdown_o = s_q.powerdown;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_idle_request;
    s_q.mode == ipc_pkg::IPC_RUN && enter_any && !pc_wr[ipc_pkg::BIT_POWERDOWN_REQ];
  endsequence

  sequence s_powerdown_request;
    s_q.mode == ipc_pkg::IPC_RUN && enter_any && pc_wr[ipc_pkg::BIT_POWERDOWN_REQ];
  endsequence

  sequence s_port1_wake;
    s_q.mode == ipc_pkg::IPC_POWERDOWN && wake_hit;
  endsequence

  a_idle_entry: assert property (s_idle_request |=>
    idle_o && !cpu_clk_en_o && periph_clk_en_o)
    else $error("Idle not entered after the requesting instruction.");

  a_idle_pins: assert property (idle_o |->
    strobe_force_o && strobe_level_o && port_freeze_o && !cpu_clk_en_o)
    else $error("Idle pins or strobes not held.");

  a_idle_exit: assert property (idle_o && irq_pending_i |=>
    !idle_o && cpu_clk_en_o && s_q.power_control[1:0] == 2'b00)
    else $error("Interrupt did not end Idle.");

  a_powerdown_entry: assert property (s_powerdown_request |=>
    powerdown_o && !osc_en_o && !cpu_clk_en_o && !periph_clk_en_o)
    else $error("Power-down not entered or oscillator still running.");

  a_powerdown_pins: assert property (powerdown_o |->
    strobe_force_o && !strobe_level_o && port2_latch_sel_o)
    else $error("Power-down strobes not driven low.");

  a_powerdown_extbus: assert property (s_powerdown_request ##0 ext_access_i |=>
    port0_float_o && port2_latch_sel_o)
    else $error("Port 0 not floated after power-down in an external access.");

  a_wake_hold: assert property (s_port1_wake |=>
    (!cpu_clk_en_o && osc_en_o) [*8])
    else $error("Port-1 wake settling delay wrong.");

  // The full settling length is judged on the tally, since it is far too long to unroll.
  a_wake_length: assert property (
    $rose(cpu_clk_en_o) && $past(s_q.mode) == ipc_pkg::IPC_WAKE |->
    s_q.wake_cnt >= WAKE_DELAY_CYCLES && s_q.wake_cnt <= WAKE_DELAY_CYCLES + 4)
    else $error("Port-1 wake settling delay has the wrong length.");

  a_wake_pins: assert property (s_q.mode == ipc_pkg::IPC_WAKE |->
    osc_en_o && !cpu_clk_en_o && port2_latch_sel_o && !powerdown_o)
    else $error("Clocks or pins wrong while the oscillator settles.");

  a_powerdown_clocks: assert property (powerdown_o |->
    !osc_en_o && !periph_clk_en_o && !cpu_clk_en_o)
    else $error("A clock still runs in Power-down.");

  a_byte_only: assert property (sfr_wr_i && sfr_bit_wr_i && s_q.mode == ipc_pkg::IPC_RUN |=>
    $stable(s_q.power_control))
    else $error("Bit write changed the power control register.");

  a_reserved_zero: assert property (sfr_rdata_o[6:4] == 3'b000)
    else $error("Reserved power control bits read non-zero.");

  a_flags_kept: assert property (idle_o && irq_pending_i |=>
    s_q.power_control[3:2] == $past(s_q.power_control[3:2]))
    else $error("General flags lost on Idle wake.");

  a_mc_period: assert property (mc_strobe_o && !powerdown_o |=>
    (!mc_strobe_o || powerdown_o) [*8])
    else $error("Machine cycle strobe too frequent.");

endmodule // ipc_power_ctrl

// >>> tb/test_idle_powerdown_controller.sv
`timescale 1ns/10ps
module test_idle_powerdown_controller;
  // Stimulus towards the controller, all driven on the falling edge.
  logic clk_i;
  logic rst_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic sfr_bit_wr_i;
  logic sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic instr_done_i;
  logic irq_pending_i;
  logic ext_access_i;
  logic [7:0] port1_wake_irq_i;
  logic [7:0] port1_wake_en_i;
  // Observed outputs.
  logic [7:0] sfr_rdata_o;
  logic cpu_clk_en_o;
  logic periph_clk_en_o;
  logic osc_en_o;
  logic mc_strobe_o;
  logic strobe_force_o;
  logic strobe_level_o;
  logic port_freeze_o;
  logic port2_latch_sel_o;
  logic port0_float_o;
  logic baud_double_o;
  logic idle_o;
  logic powerdown_o;
  logic [9:0] st;
  int error_cnt;
  int checks;
  int n;

  // Mode and pin outputs packed as one word so a whole mode is compared at once.
  assign st = {cpu_clk_en_o, periph_clk_en_o, osc_en_o, strobe_force_o, strobe_level_o,
    port_freeze_o, port2_latch_sel_o, port0_float_o, idle_o, powerdown_o};

  ipc_power_ctrl #(
    .WAKE_DELAY_CYCLES(ipc_pkg::WAKE_DELAY_CYCLES),
    .MC_CYCLES(ipc_pkg::MC_CYCLES)
  ) i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_bit_wr_i(sfr_bit_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .instr_done_i(instr_done_i),
    .irq_pending_i(irq_pending_i),
    .ext_access_i(ext_access_i),
    .port1_wake_irq_i(port1_wake_irq_i),
    .port1_wake_en_i(port1_wake_en_i),
    .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o),
    .osc_en_o(osc_en_o),
    .mc_strobe_o(mc_strobe_o),
    .strobe_force_o(strobe_force_o),
    .strobe_level_o(strobe_level_o),
    .port_freeze_o(port_freeze_o),
    .port2_latch_sel_o(port2_latch_sel_o),
    .port0_float_o(port0_float_o),
    .baud_double_o(baud_double_o),
    .idle_o(idle_o),
    .powerdown_o(powerdown_o)
  );

  // The oscillator clock, 4 ns period.
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Verdict in one place; every hang limit ends here too.
  task automatic results();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Register byte compare.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Mode word compare.
  task automatic chk_mode(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single flag compare.
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A wait that ran out of its bound is a failure and stops the run.
  task automatic hang();
    error_cnt++;
    $display("mismatch t=%0t got=%h exp=%h", $time, st, 10'h000);
    results();
  endtask

  // One register write, byte or bit-wise; the completion pulse may ride along with it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw,
                    input logic done);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_bit_wr_i = bw;
    sfr_wr_i = 1'b1;
    instr_done_i = done;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    sfr_bit_wr_i = 1'b0;
    instr_done_i = 1'b0;
  endtask

  // One read; the registered data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    chk_byte(sfr_rdata_o, exp);
  endtask

  // Hardware reset pulse of a given length.
  task automatic do_reset(input int cyc);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (cyc) @(negedge clk_i);
    rst_i = 1'b0;
  endtask

  // Counts machine-cycle strobes over a window, to see whether the timing chain runs.
  task automatic count_mc(input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(negedge clk_i);
      if (mc_strobe_o === 1'b1)
        n++;
    end
  endtask

  // Main sequence.
  initial
  begin
    rst_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_bit_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_wdata_i = 8'h00;
    instr_done_i = 1'b0;
    irq_pending_i = 1'b0;
    ext_access_i = 1'b0;
    port1_wake_irq_i = 8'h00;
    port1_wake_en_i = 8'h00;
    error_cnt = 0;
    checks = 0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk_mode(st, 10'h380);
    rd(8'h87, 8'h00);
    // Register map: reserved bits drop, bit writes and other addresses are ignored.
    wr(8'h87, 8'hfc, 1'b0, 1'b0);
    rd(8'h87, 8'h8c);
    chk_flag(baud_double_o, 1'b1);
    wr(8'h87, 8'h00, 1'b1, 1'b0);
    wr(8'h86, 8'h00, 1'b0, 1'b0);
    rd(8'h87, 8'h8c);
    rd(8'h86, 8'h00);
    // Idle waits for the completing instruction, which may come later.
    wr(8'h87, 8'h0d, 1'b0, 1'b0);
    chk_mode(st, 10'h380);
    wr(8'h80, 8'h00, 1'b0, 1'b1);
    chk_mode(st, 10'h1f2);
    count_mc(24);
    chk_byte(n[7:0], 8'h02);
    chk_mode(st, 10'h1f2);
    @(negedge clk_i);
    irq_pending_i = 1'b1;
    @(negedge clk_i);
    irq_pending_i = 1'b0;
    chk_mode(st, 10'h380);
    rd(8'h87, 8'h0c);
    // Idle left by a reset of two machine cycles.
    wr(8'h87, 8'h8d, 1'b0, 1'b1);
    chk_mode(st, 10'h1f2);
    do_reset(24);
    chk_mode(st, 10'h380);
    rd(8'h87, 8'h00);
    // Both requests at once during an external access: power-down wins.
    ext_access_i = 1'b1;
    wr(8'h87, 8'h83, 1'b0, 1'b1);
    chk_mode(st, 10'h04d);
    irq_pending_i = 1'b1;
    count_mc(24);
    irq_pending_i = 1'b0;
    chk_byte(n[7:0], 8'h00);
    chk_mode(st, 10'h04d);
    // A disabled wake pin must not wake the device.
    port1_wake_irq_i = 8'h80;
    repeat (8) @(negedge clk_i);
    chk_mode(st, 10'h04d);
    port1_wake_en_i = 8'h80;
    n = 0;
    while (powerdown_o !== 1'b0 && n < 10)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 10)
      hang();
    port1_wake_irq_i = 8'h00;
    // The settling delay keeps the CPU clock off for the full count.
    n = 0;
    while (cpu_clk_en_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000)
      hang();
    chk_flag(n >= ipc_pkg::WAKE_DELAY_CYCLES && n <= ipc_pkg::WAKE_DELAY_CYCLES + 9,
      1'b1);
    @(negedge clk_i);
    chk_mode(st, 10'h380);
    rd(8'h87, 8'h80);
    // Power-down left by reset: no settling delay afterwards.
    ext_access_i = 1'b0;
    port1_wake_en_i = 8'h00;
    wr(8'h87, 8'h02, 1'b0, 1'b1);
    chk_mode(st, 10'h049);
    do_reset(24);
    chk_mode(st, 10'h380);
    rd(8'h87, 8'h00);
    results();
  end

endmodule // test_idle_powerdown_controller
